//--- logic/branch_pkg.sv
// Package: encodings, flag positions and carriers for the conditional branch unit
//------------------------------------------------------------
// Contract
// - Generic clear-test: jump by offset plus one when the chosen flag is 0
// - Branch on equal: jump only when the zero flag is 1
// - Branch on unequal: jump only when the zero flag is 0
// - Carry-one branch: jump only when carry is 1
// - Carry-zero branch: jump only when carry is 0
// - Same-or-higher branch: jump when carry is 0
// - Unsigned lower branch: jump when carry is 1
// - Negative branch: jump when sign flag is 1
// - Positive branch: jump when sign flag is 0
// - Signed greater-or-equal: jump when sign xor overflow is 0
// - Signed less-than: jump when sign xor overflow is 1
// - Half-carry-one branch: jump when half carry is 1
// - Half-carry-zero branch: jump when half carry is 0
// - Copy-bit-one branch: jump when copy flag is 1
// - Copy-bit-zero branch: jump when copy flag is 0
// - Overflow-one branch: jump when overflow flag is 1
// - Branches never change flags; they take one or two cycles
//------------------------------------------------------------
package branch_pkg;

  //------------------------------------------------------------
  // Flag register bit positions
  //------------------------------------------------------------
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_ZERO  = 1;
  localparam int FLAG_SIGN  = 2;
  localparam int FLAG_OVF   = 3;
  localparam int FLAG_NSV   = 4;
  localparam int FLAG_HALF  = 5;
  localparam int FLAG_COPY  = 6;

  localparam int OFFSET_W = 7;
  localparam int PC_W     = 16;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP  = 16'h0001;

  //------------------------------------------------------------
  // Branch operations
  //------------------------------------------------------------
  typedef enum logic [4:0] {
    branch_none,
    branch_flag_clear,
    branch_on_equal,
    branch_on_unequal,
    branch_carry_one,
    branch_carry_zero,
    branch_same_higher,
    branch_unsigned_lower,
    branch_negative,
    branch_positive,
    branch_ge_signed,
    branch_lt_signed,
    branch_half_one,
    branch_half_zero,
    branch_copy_one,
    branch_copy_zero,
    branch_overflow_one
  } branch_op_t;

  typedef struct packed {
    branch_op_t          op;
    logic [2:0]          flag_index;
    logic [OFFSET_W-1:0] offset;
  } branch_req_t;

  typedef struct packed {
    logic            taken;
    logic            busy;
    logic [PC_W-1:0] program_counter;
  } branch_out_t;

endpackage

//--- logic/branch_cond.sv
// Condition evaluator: decides whether a branch is taken from the flags
`timescale 1ns/1ps
module branch_cond
  import branch_pkg::*;
(
  // Request
  input  wire branch_op_t  op,
  input  wire logic [2:0]  flag_index,
  // Flags
  input  wire logic [7:0]  flag_register,
  // Decision
  output logic             take
);

  logic sign_xor_ovf;
  assign sign_xor_ovf = flag_register[FLAG_SIGN] ^ flag_register[FLAG_OVF];

  always_comb begin
    case (op)
      branch_flag_clear:     take = ~flag_register[flag_index];
      branch_on_equal:       take = flag_register[FLAG_ZERO];
      branch_on_unequal:     take = ~flag_register[FLAG_ZERO];
      branch_carry_one:      take = flag_register[FLAG_CARRY];
      branch_carry_zero:     take = ~flag_register[FLAG_CARRY];
      branch_same_higher:    take = ~flag_register[FLAG_CARRY];
      branch_unsigned_lower: take = flag_register[FLAG_CARRY];
      branch_negative:       take = flag_register[FLAG_SIGN];
      branch_positive:       take = ~flag_register[FLAG_SIGN];
      branch_ge_signed:      take = ~sign_xor_ovf;
      branch_lt_signed:      take = sign_xor_ovf;
      branch_half_one:       take = flag_register[FLAG_HALF];
      branch_half_zero:      take = ~flag_register[FLAG_HALF];
      branch_copy_one:       take = flag_register[FLAG_COPY];
      branch_copy_zero:      take = ~flag_register[FLAG_COPY];
      branch_overflow_one:   take = flag_register[FLAG_OVF];
      default:               take = 1'b0;
    endcase
  end

endmodule

//--- logic/conditional_branch_unit.sv
// Conditional branch unit: evaluates conditions and updates the program counter
`timescale 1ns/1ps
module conditional_branch_unit
  import branch_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Instruction
  input  wire logic              instr_valid,
  input  wire branch_req_t       req,
  // Flags, read only
  input  wire logic [7:0]        flag_register,
  // Results
  output branch_out_t            result,
  output logic [7:0]             flag_out
);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef enum {st_idle, st_jump} state_t;

  state_t          state;
  state_t          next_state;
  logic [PC_W-1:0] next_pc;
  logic            next_taken;
  logic            next_busy;
  logic [7:0]      next_flag_out;
  logic            take;
  logic [PC_W-1:0] target;

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                  input logic [OFFSET_W-1:0] k);
    logic [PC_W-1:0] k_ext;
    k_ext = {{(PC_W-OFFSET_W){k[OFFSET_W-1]}}, k};
    return pc + k_ext + PC_STEP;
  endfunction

  branch_cond u_cond (
    .op            (req.op),
    .flag_index    (req.flag_index),
    .flag_register (flag_register),
    .take          (take)
  );

  // Target held for the second cycle of a taken branch
  logic [PC_W-1:0] next_target;

  always_comb begin
    next_state    = state;
    next_pc       = result.program_counter;
    next_taken    = 1'b0;
    next_busy     = 1'b0;
    next_target   = target;
    next_flag_out = flag_register;
    case (state)
      st_idle: begin
        if (instr_valid && req.op != branch_none) begin
          if (take) begin
            next_target = rel_target(result.program_counter, req.offset);
            next_busy   = 1'b1;
            next_state  = st_jump;
          end else begin
            next_pc = result.program_counter + PC_STEP;
          end
        end
      end
      st_jump: begin
        next_pc    = target;
        next_taken = 1'b1;
        next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state                  <= st_idle;
      result.program_counter <= PC_RESET;
      result.taken           <= 1'b0;
      result.busy            <= 1'b0;
      target                 <= PC_RESET;
      flag_out               <= 8'h00;
    end else begin
      state                  <= next_state;
      result.program_counter <= next_pc;
      result.taken           <= next_taken;
      result.busy            <= next_busy;
      target                 <= next_target;
      flag_out               <= next_flag_out;
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  sequence s_taken_req;
    state == st_idle && instr_valid && req.op != branch_none && take;
  endsequence

  sequence s_jump_done(logic [PC_W-1:0] t);
    result.busy ##1 (result.taken && result.program_counter == t);
  endsequence

  sequence s_no_req;
    state == st_idle && !(instr_valid && req.op != branch_none);
  endsequence

  taken_two_cycles_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_taken_req |=> s_jump_done(rel_target($past(result.program_counter, 2),
                                           $past(req.offset, 2))))
    else $error("taken branch target or timing wrong");

  fall_through_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == st_idle && instr_valid && req.op != branch_none && !take)
      |=> (result.program_counter == $past(result.program_counter) + PC_STEP && !result.busy))
    else $error("not-taken branch did not step once");

  flags_kept_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> flag_out == $past(flag_register))
    else $error("flags altered by branch");

  equal_cond_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_on_equal |-> take == flag_register[FLAG_ZERO])
    else $error("equal condition wrong");

  clear_cond_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_flag_clear |-> take == !flag_register[req.flag_index])
    else $error("clear-test condition wrong");

  signed_ge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_ge_signed |-> take == !(flag_register[FLAG_SIGN] ^ flag_register[FLAG_OVF]))
    else $error("signed ge condition wrong");

  signed_lt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_lt_signed |-> take == (flag_register[FLAG_SIGN] ^ flag_register[FLAG_OVF]))
    else $error("signed lt condition wrong");

  carry_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.op == branch_carry_zero || req.op == branch_same_higher)
      |-> take == !flag_register[FLAG_CARRY])
    else $error("carry-zero condition wrong");

  lower_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (req.op == branch_carry_one || req.op == branch_unsigned_lower)
      |-> take == flag_register[FLAG_CARRY])
    else $error("carry-one condition wrong");

  overflow_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_overflow_one |-> take == flag_register[FLAG_OVF])
    else $error("overflow condition wrong");

  //------------------------------------------------------------
  // Remaining condition checks
  //------------------------------------------------------------

  unequal_cond_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_on_unequal
      |-> take == !flag_register[FLAG_ZERO])
    else $error("unequal condition wrong");

  carry_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_carry_one
      |-> take == flag_register[FLAG_CARRY])
    else $error("carry-one condition wrong");

  same_higher_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_same_higher
      |-> take == !flag_register[FLAG_CARRY])
    else $error("same-or-higher condition wrong");

  negative_cond_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_negative
      |-> take == flag_register[FLAG_SIGN])
    else $error("negative condition wrong");

  positive_cond_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_positive
      |-> take == !flag_register[FLAG_SIGN])
    else $error("positive condition wrong");

  half_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_half_one
      |-> take == flag_register[FLAG_HALF])
    else $error("half-carry-one condition wrong");

  half_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_half_zero
      |-> take == !flag_register[FLAG_HALF])
    else $error("half-carry-zero condition wrong");

  copy_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_copy_one
      |-> take == flag_register[FLAG_COPY])
    else $error("copy-one condition wrong");

  copy_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req.op == branch_copy_zero
      |-> take == !flag_register[FLAG_COPY])
    else $error("copy-zero condition wrong");

  //------------------------------------------------------------
  // Sequencing checks
  //------------------------------------------------------------
  jump_refuses_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == st_jump
      |=> (state == st_idle && result.taken && !result.busy))
    else $error("request accepted during busy cycle");

  taken_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    result.taken |=> !result.taken)
    else $error("taken held longer than one cycle");

  idle_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_no_req |=> (result.program_counter == $past(result.program_counter)
                  && !result.busy && !result.taken))
    else $error("pc moved without a branch");

  busy_cause_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    result.busy |-> $past(state == st_idle && instr_valid && take))
    else $error("busy without a taken branch");

endmodule

//--- sim/conditional_branch_unit_tb.sv
// Self-checking testbench for the conditional branch unit
`timescale 1ns/1ps
module conditional_branch_unit_tb;
  import branch_pkg::*;

  //------------------------------------------------------------
  // Signals and design
  //------------------------------------------------------------
  logic        clk_sys;
  logic        sys_rst;
  logic        instr_valid;
  branch_req_t req;
  logic [7:0]  flag_register;
  branch_out_t result;
  logic [7:0]  flag_out;
  int          fail_count;
  int          cmp_count;
  int          cycle_count;
  integer      seed;
  logic [15:0] exp_pc;

  conditional_branch_unit dut (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst),
    .instr_valid   (instr_valid),
    .req           (req),
    .flag_register (flag_register),
    .result        (result),
    .flag_out      (flag_out)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycle_count = cycle_count + 1;
    if (cycle_count == 3000) begin
      fail_count = fail_count + 1;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  //------------------------------------------------------------
  // Expectations and comparisons
  //------------------------------------------------------------
  function automatic logic exp_take(branch_op_t op, logic [2:0] idx, logic [7:0] f);
    case (op)
      branch_flag_clear:     return ~f[idx];
      branch_on_equal:       return f[FLAG_ZERO];
      branch_on_unequal:     return ~f[FLAG_ZERO];
      branch_carry_one:      return f[FLAG_CARRY];
      branch_carry_zero:     return ~f[FLAG_CARRY];
      branch_same_higher:    return ~f[FLAG_CARRY];
      branch_unsigned_lower: return f[FLAG_CARRY];
      branch_negative:       return f[FLAG_SIGN];
      branch_positive:       return ~f[FLAG_SIGN];
      branch_ge_signed:      return ~(f[FLAG_SIGN] ^ f[FLAG_OVF]);
      branch_lt_signed:      return f[FLAG_SIGN] ^ f[FLAG_OVF];
      branch_half_one:       return f[FLAG_HALF];
      branch_half_zero:      return ~f[FLAG_HALF];
      branch_copy_one:       return f[FLAG_COPY];
      branch_copy_zero:      return ~f[FLAG_COPY];
      branch_overflow_one:   return f[FLAG_OVF];
      default:               return 1'b0;
    endcase
  endfunction

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_reset;
    chk_word(result.program_counter, 16'h0000, "reset pc");
    chk_bit(result.busy, 1'b0, "reset busy");
    chk_bit(result.taken, 1'b0, "reset taken");
    chk_word({8'h00, flag_out}, 16'h0000, "reset flags");
  endtask

  // Entered just after an edge; leaves just after the edge that ends the branch
  task automatic do_branch(input branch_op_t op, input logic [2:0] idx,
                           input logic [6:0] off, input logic [7:0] f);
    logic tk;
    tk            = exp_take(op, idx, f);
    instr_valid   = 1'b1;
    req           = '{op: op, flag_index: idx, offset: off};
    flag_register = f;
    @(posedge clk_sys);
    #1;
    chk_bit(result.busy, tk, "busy");
    chk_word({8'h00, flag_out}, {8'h00, f}, "flags");
    if (tk) begin
      chk_word(result.program_counter, exp_pc, "pc held");
      // A request during the busy cycle must be ignored
      req.offset = ~off;
      @(posedge clk_sys);
      #1;
      exp_pc = exp_pc + {{9{off[6]}}, off} + 16'h0001;
    end else begin
      exp_pc = exp_pc + 16'h0001;
    end
    chk_bit(result.taken, tk, "taken");
    chk_word(result.program_counter, exp_pc, "pc");
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    seed          = 32'h8c74;
    fail_count    = 0;
    cmp_count     = 0;
    cycle_count   = 0;
    exp_pc        = 16'h0000;
    sys_rst       = 1'b1;
    instr_valid   = 1'b0;
    req           = '0;
    flag_register = 8'h00;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check_reset();
    $display("test reset done");
    do_branch(branch_on_equal, 3'h0, 7'h40, 8'h02);
    do_branch(branch_on_equal, 3'h0, 7'h3f, 8'h02);
    do_branch(branch_on_unequal, 3'h0, 7'h3f, 8'h02);
    $display("test offset limits done");
    for (int i = 1; i <= 16; i++) begin
      do_branch(branch_op_t'(i), 3'(i), 7'($random(seed)), 8'h00);
      do_branch(branch_op_t'(i), 3'(i), 7'($random(seed)), 8'hff);
      do_branch(branch_op_t'(i), 3'(i), 7'($random(seed)), 8'($random(seed)));
    end
    $display("test every operation done");
    for (int n = 0; n < 300; n++) begin
      do_branch(branch_op_t'(1 + {$random(seed)} % 16), 3'($random(seed)),
                7'($random(seed)), 8'($random(seed)));
    end
    $display("test random done");
    instr_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    chk_word(result.program_counter, exp_pc, "idle pc");
    chk_bit(result.busy, 1'b0, "idle busy");
    chk_word({8'h00, flag_out}, {8'h00, flag_register}, "idle flags");
    instr_valid = 1'b1;
    req.op      = branch_none;
    @(posedge clk_sys);
    #1;
    chk_word(result.program_counter, exp_pc, "none pc");
    chk_bit(result.taken, 1'b0, "none taken");
    $display("test idle done");
    do_branch(branch_positive, 3'h0, 7'h10, 8'h00);
    instr_valid = 1'b1;
    sys_rst     = 1'b1;
    @(posedge clk_sys);
    #1;
    check_reset();
    sys_rst     = 1'b0;
    exp_pc      = 16'h0000;
    do_branch(branch_overflow_one, 3'h0, 7'h02, 8'h08);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
